// ---- design/uotg_pkg.sv ----
// Constants for the OTG configuration and event block: register offsets,
// field positions, reset values and timing counts.
// Assumes a 125 MHz system clock and a 32-bit classic Wishbone register bus.
package uotg_pkg;

  // Clock and the one-millisecond base time
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MS_TIME_NS = 1000000;
  // Exact period, so no rounding is needed either way
  localparam int unsigned MS_CYCLES_DFLT = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned COUNT_W = 20;

  // Register byte offsets on the bus
  localparam int unsigned ADR_W = 8;
  localparam logic [7:0] OFS_TOKEN = 8'h00;
  localparam logic [7:0] OFS_FRAME = 8'h04;
  localparam logic [7:0] OFS_CFG1 = 8'h08;
  localparam logic [7:0] OFS_CFG2 = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_ENABLES = 8'h14;
  localparam logic [7:0] OFS_POWER = 8'h18;
  localparam logic [7:0] OFS_LINE = 8'h1C;

  // Token command fields and transaction codes
  localparam int unsigned TOKEN_PID_LSB = 4;
  localparam logic [3:0] PID_SETUP = 4'hD;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_OUT = 4'h1;

  // Configuration one fields
  localparam int unsigned C1_EYE = 7;
  localparam int unsigned C1_MON = 6;
  localparam int unsigned C1_HALT = 4;
  localparam logic [7:0] C1_MASK = 8'hD0;

  // Configuration two fields
  localparam int unsigned C2_CMPSEL = 5;
  localparam int unsigned C2_PULLUP = 4;
  localparam int unsigned C2_SERIAL = 3;
  localparam int unsigned C2_BOOST = 2;
  localparam int unsigned C2_CMPDIS = 1;
  localparam int unsigned C2_TRDIS = 0;
  localparam logic [7:0] C2_MASK = 8'h3F;

  // Event flag and enable positions
  localparam int unsigned EV_ID = 7;
  localparam int unsigned EV_MS = 6;
  localparam int unsigned EV_LINE = 5;
  localparam int unsigned EV_ACT = 4;
  localparam int unsigned EV_SESV = 3;
  localparam int unsigned EV_SEND = 2;
  localparam int unsigned EV_AVLD = 0;
  localparam logic [7:0] EV_MASK = 8'hFD;

  // Power and live line status fields
  localparam int unsigned PWR_EN = 0;
  localparam int unsigned LINE_J = 7;
  localparam int unsigned LINE_SE0 = 6;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // Positions inside the synchronised input vector
  localparam int unsigned SI_ID = 0;
  localparam int unsigned SI_SE0 = 1;
  localparam int unsigned SI_J = 2;
  localparam int unsigned SI_DP = 3;
  localparam int unsigned SI_DM = 4;
  localparam int unsigned SI_CSV = 5;
  localparam int unsigned SI_CSE = 6;
  localparam int unsigned SI_CAV = 7;
  localparam int unsigned SI_X0 = 8;
  localparam int unsigned SI_X1 = 9;
  localparam int unsigned SI_X2 = 10;
  localparam int unsigned SYNC_W = 11;

endpackage : uotg_pkg

// ---- design/uotg_cfg_evt.sv ----
// OTG host token, frame threshold, configuration and OTG event registers.
// Assumes a 125 MHz clk, classic Wishbone master, pin inputs asynchronous,
// and drive_active_i / cpu_idle_i coming from logic on clk.
`timescale 1ns/1ps

// Functional notes
// - Token nibble 1101 is SETUP, 1001 IN, 0001 OUT, all in host mode.
// - Eight-bit frame threshold holds ten plus packet size in bytes.
// - Eye-pattern test runs while its enable bit is set and the module runs.
// - Monitor bit lets the active-low drive indicator show driving intervals.
// - Transceiver disable keeps the drive indicator active regardless.
// - Halt-in-idle stops the module while the processor idles.
// - With comparator off, select picks three-pin or two-pin status form.
// - Pull-up enable switches the bus power pin pull-up on or off.
// - Serial control select chooses serial bus or dedicated pins.
// - Boost disable turns off builder and enables external supply control.
// - Comparator disable takes bus power status from digital inputs.
// - Transceiver disable turns off on-chip transceiver for external one.
// - Flags set by hardware, reset to zero, write one clears.
// - A change on the ID pin sets the ID change flag.
// - Each one-millisecond timer expiry sets the timer flag.
// - Line state stable 1 ms and new sets the line flag.
// - Activity on data lines or bus power sets the activity flag.
// - Each bus power threshold crossing, either way, sets its own flag; in the two-pin form a session valid crossing also sets the A-valid flag.
// - Enables share flag positions, reset zero; bit 1 reads zero.
// - Power enable bit gates event detection, token launch and the run output.
// - Live J and single-ended-zero bits together define line state.
module uotg_cfg_evt
  import uotg_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DFLT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cpu_idle_i,
  input wire logic drive_active_i,
  input wire logic id_pin_i,
  input wire logic line_se0_i,
  input wire logic line_j_i,
  input wire logic dp_rx_i,
  input wire logic dm_rx_i,
  input wire logic cmp_sess_valid_i,
  input wire logic cmp_sess_end_i,
  input wire logic cmp_a_valid_i,
  input wire logic [2:0] ext_vbus_status_i,
  output logic module_run_o,
  output logic [3:0] token_pid_o,
  output logic [3:0] token_endpoint_number_o,
  output logic token_start_o,
  output logic token_dir_tx_o,
  output logic [7:0] frame_threshold_value_o,
  output logic eye_test_enable_o,
  output logic drive_indicator_n_o,
  output logic bus_power_pullup_enable_o,
  output logic external_module_serial_control_o,
  output logic boost_builder_disable_o,
  output logic ext_supply_control_enable_o,
  output logic bus_power_comparator_disable_o,
  output logic onchip_transceiver_disable_o,
  output logic otg_irq_o
);

  // Elaboration check: the counters must be able to reach the period
  if (MS_CYCLES < 2 || MS_CYCLES >= (1 << COUNT_W)) begin : g_chk
    $error("MS_CYCLES out of range for the millisecond counters");
  end

  localparam logic [COUNT_W-1:0] MS_LAST = COUNT_W'(MS_CYCLES - 1);

  typedef struct packed {
    logic [7:0] token;
    logic [7:0] frame;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] flags;
    logic [7:0] enables;
    logic power;
    logic ack;
    logic [31:0] rdata;
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] prev;
    logic [COUNT_W-1:0] ms_count;
    logic [COUNT_W-1:0] line_count;
    logic [1:0] line_reported;
    logic token_start;
    logic run;
    logic drive_ind;
    logic irq;
  } uotg_state_s;

  uotg_state_s s_q;
  uotg_state_s s_d;

  logic [SYNC_W-1:0] raw_in;
  logic req;
  logic wr;
  logic active;
  logic [2:0] vbus_now;
  logic [2:0] vbus_old;
  logic [1:0] line_now;
  logic [7:0] ev;
  logic [7:0] clr;
  logic [31:0] rd;

  // Select the bus power status source; the two-pin form lacks an A-side
  // valid line, so session valid stands in for it
  function automatic logic [2:0] vbus_pick(
    input logic [SYNC_W-1:0] v,
    input logic cmp_off,
    input logic three_pin
  );
    logic [2:0] r;
    if (!cmp_off) begin
      r = {v[SI_CAV], v[SI_CSV], v[SI_CSE]};
    end else if (three_pin) begin
      r = {v[SI_X2], v[SI_X1], v[SI_X0]};
    end else begin
      r = {v[SI_X1], v[SI_X1], v[SI_X0]};
    end
    return r;
  endfunction : vbus_pick

  // Raw pin levels gathered for the synchroniser
  assign raw_in = {ext_vbus_status_i, cmp_a_valid_i, cmp_sess_end_i,
                   cmp_sess_valid_i, dm_rx_i, dp_rx_i, line_j_i,
                   line_se0_i, id_pin_i};

  // Bus request decode
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & s_q.ack & wb_we_i & wb_sel_i[0];

  // Whole next-state computation
  always_comb begin
    s_d = s_q;
    active = s_q.power & ~(s_q.cfg1[C1_HALT] & cpu_idle_i);
    // Second stage only feeds later logic; first stage read by nothing else
    s_d.sync1 = raw_in;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    vbus_now = vbus_pick(s_q.sync2, s_q.cfg2[C2_CMPDIS],
                         s_q.cfg2[C2_CMPSEL]);
    vbus_old = vbus_pick(s_q.prev, s_q.cfg2[C2_CMPDIS],
                         s_q.cfg2[C2_CMPSEL]);
    line_now = {s_q.sync2[SI_J], s_q.sync2[SI_SE0]};
    ev = 8'h00;

    // Event detection runs only while the module is enabled and awake
    if (active) begin
      ev[EV_ID] = s_q.sync2[SI_ID] ^ s_q.prev[SI_ID];
      // Free-running millisecond timer
      if (s_q.ms_count == MS_LAST) begin
        s_d.ms_count = '0;
        ev[EV_MS] = 1'b1;
      end else begin
        s_d.ms_count = s_q.ms_count + COUNT_W'(1);
      end
      // Line state must hold one full period and differ from last report
      if (line_now != {s_q.prev[SI_J], s_q.prev[SI_SE0]}) begin
        s_d.line_count = '0;
      end else if (s_q.line_count != MS_LAST) begin
        s_d.line_count = s_q.line_count + COUNT_W'(1);
      end else if (line_now != s_q.line_reported) begin
        ev[EV_LINE] = 1'b1;
        s_d.line_reported = line_now;
      end
      ev[EV_ACT] = (s_q.sync2[SI_DP] ^ s_q.prev[SI_DP]) |
                   (s_q.sync2[SI_DM] ^ s_q.prev[SI_DM]) |
                   (vbus_now != vbus_old);
      ev[EV_SESV] = vbus_now[1] ^ vbus_old[1];
      ev[EV_SEND] = vbus_now[0] ^ vbus_old[0];
      ev[EV_AVLD] = vbus_now[2] ^ vbus_old[2];
    end else begin
      s_d.ms_count = '0;
      s_d.line_count = '0;
    end

    // Register writes take effect at the edge where ack is sampled
    clr = 8'h00;
    s_d.token_start = 1'b0;
    if (wr) begin
      unique case (wb_adr_i)
        OFS_TOKEN: begin
          s_d.token = wb_dat_i[7:0];
          // Reserved codes never launch a transaction
          s_d.token_start = s_q.power &
            (wb_dat_i[7:4] == PID_SETUP || wb_dat_i[7:4] == PID_IN ||
             wb_dat_i[7:4] == PID_OUT);
        end
        OFS_FRAME: s_d.frame = wb_dat_i[7:0];
        OFS_CFG1: s_d.cfg1 = wb_dat_i[7:0] & C1_MASK;
        OFS_CFG2: s_d.cfg2 = wb_dat_i[7:0] & C2_MASK;
        OFS_FLAGS: clr = wb_dat_i[7:0];
        OFS_ENABLES: s_d.enables = wb_dat_i[7:0] & EV_MASK;
        OFS_POWER: s_d.power = wb_dat_i[PWR_EN];
        default: clr = 8'h00;
      endcase
    end
    // A set in the same cycle as its clear wins
    s_d.flags = ((s_q.flags & ~clr) | ev) & EV_MASK;

    // Read mux, registered alongside ack
    rd = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_TOKEN: rd[7:0] = s_q.token;
      OFS_FRAME: rd[7:0] = s_q.frame;
      OFS_CFG1: rd[7:0] = s_q.cfg1;
      OFS_CFG2: rd[7:0] = s_q.cfg2;
      OFS_FLAGS: rd[7:0] = s_q.flags;
      OFS_ENABLES: rd[7:0] = s_q.enables;
      OFS_POWER: rd[PWR_EN] = s_q.power;
      OFS_LINE: rd[LINE_J:LINE_SE0] = line_now;
      default: rd = 32'h0000_0000;
    endcase
    s_d.ack = req & ~s_q.ack;
    if (req & ~s_q.ack) begin
      s_d.rdata = rd;
    end

    // Registered outputs
    s_d.run = active;
    s_d.drive_ind = s_q.cfg2[C2_TRDIS] |
                    (s_q.cfg1[C1_MON] & drive_active_i);
    s_d.irq = |(s_q.flags & s_q.enables);
  end

  // State register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Output mapping, all from flip-flops
  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign module_run_o = s_q.run;
  assign token_pid_o = s_q.token[7:TOKEN_PID_LSB];
  assign token_endpoint_number_o = s_q.token[3:0];
  assign token_start_o = s_q.token_start;
  assign token_dir_tx_o = (s_q.token[7:TOKEN_PID_LSB] != PID_IN);
  assign frame_threshold_value_o = s_q.frame;
  assign eye_test_enable_o = s_q.cfg1[C1_EYE] & s_q.run;
  assign drive_indicator_n_o = ~s_q.drive_ind;
  assign bus_power_pullup_enable_o = s_q.cfg2[C2_PULLUP];
  assign external_module_serial_control_o = s_q.cfg2[C2_SERIAL];
  assign boost_builder_disable_o = s_q.cfg2[C2_BOOST];
  assign ext_supply_control_enable_o = s_q.cfg2[C2_BOOST];
  assign bus_power_comparator_disable_o = s_q.cfg2[C2_CMPDIS];
  assign onchip_transceiver_disable_o = s_q.cfg2[C2_TRDIS];
  assign otg_irq_o = s_q.irq;

  // ID edge reaches its flag one cycle after the synchronised change
  id_flag_set_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (s_q.run && s_q.power && (s_q.sync2[SI_ID] != s_q.prev[SI_ID])
     && !(cpu_idle_i && s_q.cfg1[C1_HALT]))
    |=> s_q.flags[EV_ID])
    else $error("ID change did not set its flag");

  // Write one clears a flag unless a new event arrives
  w1c_clear_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr && wb_adr_i == OFS_FLAGS && wb_dat_i[EV_SEND] && ev[EV_SEND] == 1'b0)
    |=> !s_q.flags[EV_SEND])
    else $error("Flag not cleared by write one");

  // Set wins over clear in the same cycle
  set_over_clear_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr && wb_adr_i == OFS_FLAGS && ev[EV_ACT]) |=> s_q.flags[EV_ACT])
    else $error("Event lost to a simultaneous clear");

  // Unimplemented bit stays zero
  unimpl_zero_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !s_q.flags[1] && !s_q.enables[1])
    else $error("Unimplemented bit 1 became set");

  // Interrupt follows flags and enables one cycle later
  irq_follow_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (|(s_q.flags & s_q.enables)) |=> otg_irq_o)
    else $error("Interrupt missing for an enabled flag");

  // Interrupt drops once no enabled flag remains
  irq_quiet_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !(|(s_q.flags & s_q.enables)) |=> !otg_irq_o)
    else $error("Interrupt raised without an enabled flag");

  // Transceiver disable forces the drive indicator active
  drive_force_a: assert property (
    @(posedge clk) disable iff (!nrst)
    s_q.cfg2[C2_TRDIS] [*2] |-> !drive_indicator_n_o)
    else $error("Drive indicator inactive with transceiver off");

  // Indicator quiet when neither monitor nor transceiver disable is set
  drive_quiet_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (!s_q.cfg1[C1_MON] && !s_q.cfg2[C2_TRDIS]) |=> drive_indicator_n_o)
    else $error("Drive indicator active while monitoring is off");

  // Halt in idle stops the module within one cycle
  idle_halt_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (s_q.cfg1[C1_HALT] && cpu_idle_i) |=> !module_run_o)
    else $error("Module kept running in idle with halt set");

  // Timer expiry at the period boundary sets the flag and restarts the count at zero
  ms_timer_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (active && s_q.ms_count == MS_LAST) |=>
      (s_q.flags[EV_MS] && s_q.ms_count == '0))
    else $error("Millisecond timer expiry missed");

  // Reserved token codes never start a transaction
  token_code_a: assert property (
    @(posedge clk) disable iff (!nrst)
    token_start_o |-> (token_pid_o == PID_SETUP || token_pid_o == PID_IN ||
                       token_pid_o == PID_OUT))
    else $error("Transaction started with a reserved token code");

  // Line flag needs the state held a full period first
  line_stable_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (!s_q.flags[EV_LINE] ##1 s_q.flags[EV_LINE]) |->
      $past(s_q.line_count) == MS_LAST)
    else $error("Line flag set before the state was stable");

  // A disabled or halted module sets no new flag; clears still work
  inactive_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !active |=> ((s_q.flags & ~$past(s_q.flags)) == 8'h00))
    else $error("Flag set while the module was inactive");

  // Unpowered module never reports itself running
  power_off_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !s_q.power |=> !module_run_o)
    else $error("Module running with power enable clear");

  // A token is launched only while the module is powered
  token_power_a: assert property (
    @(posedge clk) disable iff (!nrst)
    token_start_o |-> s_q.power)
    else $error("Token launched while unpowered");

  // Acknowledge is a single-cycle pulse
  ack_pulse_a: assert property (
    @(posedge clk) disable iff (!nrst)
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held for more than one cycle");

  // Upper read data bits are unimplemented and read zero
  read_upper_a: assert property (
    @(posedge clk) disable iff (!nrst)
    wb_ack_o |-> (wb_dat_o[31:8] == 24'h00_0000))
    else $error("Upper read data bits not zero");

endmodule : uotg_cfg_evt

// ---- dv/uotg_cable_model.sv ----
// Cable-side model: ID, line, data and bus power pins of the far side.
// Assumes the bench calls drive() and that pins only move at clock edges.
`timescale 1ns/1ps
module uotg_cable_model (
  input wire logic clk,
  output logic [10:0] pins_o
);
  // Bit order follows the synchroniser vector: id, se0, j, dp, dm,
  // three comparator levels, then the external status form
  initial pins_o = 11'h000;

  // Pins are always driven, so nothing is ever left floating
  task automatic drive(input logic [10:0] v);
    @(posedge clk);
    pins_o <= v;
  endtask : drive
endmodule : uotg_cable_model

// ---- dv/uotg_cfg_evt_test.sv ----
// Self-checking bench for the OTG configuration and event registers.
// Assumes a short millisecond count and the cable model on the pins.
`timescale 1ns/1ps
module uotg_cfg_evt_test;
  import uotg_pkg::*;
  localparam int MS = 16;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } uotg_row_s;
  uotg_row_s rows[9];
  logic clk, nrst, cyc, stb, we, idle, drv, ack, run, start, dtx;
  logic eye, drv_n, irq;
  logic [7:0] adr, thr, ev[8];
  logic [3:0] sel, pid, ep, codes[4];
  logic [31:0] wdat, rdat, dat_o;
  logic [10:0] pins, pv;
  logic [5:0] c2o;
  int n_fail, total_checks, n_start, k, p;

  uotg_cable_model u_cable (.clk(clk), .pins_o(pv));
  uotg_cfg_evt #(.MS_CYCLES(MS)) u_dut (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .cpu_idle_i(idle),
    .drive_active_i(drv), .id_pin_i(pv[SI_ID]),
    .line_se0_i(pv[SI_SE0]), .line_j_i(pv[SI_J]), .dp_rx_i(pv[SI_DP]),
    .dm_rx_i(pv[SI_DM]), .cmp_sess_valid_i(pv[SI_CSV]),
    .cmp_sess_end_i(pv[SI_CSE]), .cmp_a_valid_i(pv[SI_CAV]),
    .ext_vbus_status_i(pv[10:8]), .module_run_o(run),
    .token_pid_o(pid), .token_endpoint_number_o(ep),
    .token_start_o(start), .token_dir_tx_o(dtx),
    .frame_threshold_value_o(thr), .eye_test_enable_o(eye),
    .drive_indicator_n_o(drv_n), .bus_power_pullup_enable_o(c2o[5]),
    .external_module_serial_control_o(c2o[4]),
    .boost_builder_disable_o(c2o[3]),
    .ext_supply_control_enable_o(c2o[2]),
    .bus_power_comparator_disable_o(c2o[1]),
    .onchip_transceiver_disable_o(c2o[0]), .otg_irq_o(irq)
  );

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Counted on the falling edge so the pulse is settled
  always @(negedge clk) begin
    if (start === 1'b1) n_start++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step

  // One classic cycle; held until ack is sampled high at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      n_fail++;
      end_of_test();
    end else begin
      // Write lands and read data is taken at this same edge
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdat & m, e);
  endtask : rchk

  // Reset held 12 cycles; every register up to power then reads zero, line status unread
  task automatic reset_and_check;
    @(posedge clk);
    nrst <= 1'b0;
    step(12);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) rchk(8'(4 * i), 32'hFFFF_FFFF, 0);
    chk(drv_n, 1'b1);
    chk({dtx, irq, run}, 3'b100);
  endtask : reset_and_check

  initial begin
    {cyc, stb, we, idle, drv} = 5'h00;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0000_0000;
    pins = 11'h000;
    n_fail = 0;
    total_checks = 0;
    n_start = 0;
    nrst = 1'b0;
    reset_and_check();
    rows = '{'{OFS_TOKEN, 32'hFFFF_FFD3, 32'h0000_00D3},
      '{OFS_FRAME, 32'h0000_004A, 32'h0000_004A},
      '{OFS_CFG1, 32'hFFFF_FFFF, 32'h0000_00D0},
      '{OFS_CFG2, 32'hFFFF_FFFF, 32'h0000_003F},
      '{OFS_ENABLES, 32'hFFFF_FFFF, 32'h0000_00FD},
      '{OFS_FLAGS, 32'h0000_00FF, 32'h0000_0000},
      '{8'h20, 32'h0000_00FF, 32'h0000_0000},
      '{OFS_LINE, 32'h0000_00FF, 32'h0000_0000},
      '{OFS_POWER, 32'h0000_0000, 32'h0000_0000}};
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      rchk(rows[i].a, 32'hFFFF_FFFF, rows[i].e);
    end
    chk(thr, 8'h4A);
    chk({c2o, drv_n}, 7'b1111110);
    // Config two cleared while the module is unpowered
    bus(1'b1, OFS_CFG2, 32'h0000_0000);
    step(2);
    chk({c2o, drv_n}, 7'b0000001);
    drv <= 1'b1;
    step(3);
    chk(drv_n, 1'b0);
    bus(1'b1, OFS_POWER, 32'h0000_0001);
    step(2);
    chk({run, eye}, 2'b11);
    idle <= 1'b1;
    step(3);
    chk({run, eye}, 2'b00);
    idle <= 1'b0;
    step(3);
    // Three defined codes plus one reserved code
    codes = '{PID_SETUP, PID_IN, PID_OUT, 4'h5};
    foreach (codes[i]) begin
      k = n_start;
      bus(1'b1, OFS_TOKEN, {24'h0, codes[i], 4'hA});
      step(3);
      chk(n_start - k, codes[i] != 4'h5);
      chk({pid, ep, dtx}, {codes[i], 4'hA, codes[i] != PID_IN});
    end
    // Each of the first eight pins toggled up then down; timer and line bits masked out
    ev = '{8'h80, 8'h00, 8'h00, 8'h10, 8'h10, 8'h18, 8'h14, 8'h11};
    for (p = 0; p < 16; p++) begin
      bus(1'b1, OFS_FLAGS, 32'h0000_00FF);
      pins ^= 11'h001 << (p % 8);
      u_cable.drive(pins);
      step(8);
      rchk(OFS_FLAGS, 32'h0000_009D, {24'h0, ev[p % 8]});
      if (ev[p % 8] != 8'h00) chk(irq, 1'b1);
    end
    bus(1'b1, OFS_FLAGS, 32'h0000_00FF);
    pins[SI_SE0] = 1'b1;
    u_cable.drive(pins);
    step(MS + 8);
    rchk(OFS_FLAGS, 32'h0000_0020, 32'h0000_0020);
    rchk(OFS_LINE, 32'h0000_00C0, 32'h0000_0040);
    bus(1'b1, OFS_FLAGS, 32'h0000_0000);
    rchk(OFS_FLAGS, 32'h0000_0020, 32'h0000_0020);
    bus(1'b1, OFS_FLAGS, 32'h0000_0020);
    rchk(OFS_FLAGS, 32'h0000_0020, 32'h0000_0000);
    bus(1'b1, OFS_ENABLES, 32'h0000_0000);
    step(2);
    chk(irq, 1'b0);
    bus(1'b1, OFS_ENABLES, 32'h0000_0040);
    bus(1'b1, OFS_FLAGS, 32'h0000_0040);
    step(MS + 4);
    chk(irq, 1'b1);
    // External status forms: three-pin, then two-pin
    for (p = 0; p < 2; p++) begin
      bus(1'b1, OFS_POWER, 32'h0000_0000);
      bus(1'b1, OFS_CFG2, p ? 32'h0000_0002 : 32'h0000_0022);
      bus(1'b1, OFS_POWER, 32'h0000_0001);
      bus(1'b1, OFS_FLAGS, 32'h0000_00FF);
      pins ^= 11'h200;
      u_cable.drive(pins);
      step(8);
      rchk(OFS_FLAGS, 32'h0000_009D, p ? 32'h19 : 32'h18);
    end
    bus(1'b1, OFS_POWER, 32'h0000_0000);
    bus(1'b1, OFS_FLAGS, 32'h0000_00FF);
    pins ^= 11'h001;
    u_cable.drive(pins);
    step(8);
    rchk(OFS_FLAGS, 32'hFFFF_FFFF, 32'h0000_0000);
    chk(run, 1'b0);
    reset_and_check();
    end_of_test();
  end
endmodule : uotg_cfg_evt_test
